// ===== cssm_cfg.svh
// Constants for the CAN sleep-mode control block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef CSSM_CFG_SVH
`define CSSM_CFG_SVH

// Register byte offsets on the Wishbone bus.
`define CSSM_OFS_MASTER_CONTROL 8'h00
`define CSSM_OFS_GLOBAL_STATUS  8'h04
`define CSSM_OFS_IRQ_REQUEST    8'h08
`define CSSM_OFS_IRQ_MASK       8'h0C
`define CSSM_OFS_ERROR_COUNT    8'h10
`define CSSM_OFS_MAILBOX_BASE   8'h40
`define CSSM_MAILBOX_WORDS      16
`define CSSM_MAILBOX_IDX_W      4

// Field positions in master_control.
`define CSSM_BIT_SLEEP_REQUEST  5
`define CSSM_BIT_WAKE_ON_BUS    7

// Field positions in irq_request_reg and irq_mask_reg.
`define CSSM_IRQ_SLEEP          0
`define CSSM_IRQ_RX_MSG         1
`define CSSM_IRQ_WAKE           2

// Field positions in global_status.
`define CSSM_GS_SLEEP_PEND      0
`define CSSM_GS_ASLEEP          1
`define CSSM_GS_RESYNC          2

// Reset values.
`define CSSM_RST_MASTER_CONTROL 16'h0000
`define CSSM_RST_IRQ_REQUEST    16'h0000
`define CSSM_RST_IRQ_MASK       16'h0000
`define CSSM_RST_ERROR_COUNT    8'h00

// Recessive bits that must be seen before rejoining the bus.
`define CSSM_IDLE_BITS          4'hB
`define CSSM_ERR_COUNT_MAX      8'hFF

`endif

// ===== cssm_pkg.sv
// Types shared by the CAN sleep-mode control block.
// Assumes cssm_cfg.svh is on the include path.
`include "cssm_cfg.svh"

package cssm_pkg;

  // Gray codes along normal, pending, asleep, resync and back to normal.
  typedef enum logic [1:0] {
    CSSM_NORMAL = 2'h0,
    CSSM_PEND   = 2'h1,
    CSSM_SLEEP  = 2'h3,
    CSSM_RESYNC = 2'h2
  } cssm_state_t;

endpackage : cssm_pkg

// ===== cssm_recessive_count.sv
// Counter of consecutive recessive bits on the CAN bus.
// Assumes bitTick marks one sample point per bit in the clock domain.
`timescale 1ns/1ps
`include "cssm_cfg.svh"

module cssm_recessive_count
  import cssm_pkg::*;
(
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic run,
  input  wire logic bitTick,
  input  wire logic rxBit,
  output logic      idleSeen
);

  logic [3:0] count;

  // Counts recessive samples and restarts on any dominant one.
  always_ff @(posedge clock) begin
    if (srst || !run) begin
      count <= 4'h0;
    end else if (bitTick) begin
      if (!rxBit) begin
        count <= 4'h0;
      end else if (count != `CSSM_IDLE_BITS) begin
        count <= count + 4'h1;
      end
    end
  end

  assign idleSeen = run && (count == `CSSM_IDLE_BITS);

endmodule : cssm_recessive_count

// ===== cssm_sleep_ctrl.sv
// Sleep-mode control for a CAN controller, with a Wishbone slave.
// Assumes a protocol core that reports bus access, bit ticks and errors.
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cssm_cfg.svh"

module cssm_sleep_ctrl
  import cssm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatIn,
  output logic [31:0]      wbDatOut,
  output logic             wbAck,
  output logic             wbErr,
  input  wire logic        canRxPin,
  input  wire logic        coreTx,
  input  wire logic        bitTick,
  input  wire logic        busAccessBusy,
  input  wire logic        recInc,
  input  wire logic        tecInc,
  input  wire logic        rxPending,
  output logic             canTxPin,
  output logic             coreRx,
  output logic             busJoined,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations and helpers.

  cssm_state_t state;
  cssm_state_t next_state;
  logic [15:0] masterControl;
  logic [15:0] irqRequest;
  logic [15:0] irqMask;
  logic [7:0]  receiveErrorCount;
  logic [7:0]  transmitErrorCount;
  logic [15:0] mailbox [0:`CSSM_MAILBOX_WORDS-1];
  logic        rxMeta;
  logic        rxSync;
  logic        idleSeen;
  logic        busWake;
  logic        reqLive;
  logic        reqOk;
  logic        writeNow;
  logic        asleep;
  logic [15:0] statusWord;
  logic [15:0] readWord;
  logic [`CSSM_MAILBOX_IDX_W-1:0] mbIdx;

  function automatic logic isHostReg(input logic [7:0] adr);
    isHostReg = (adr == `CSSM_OFS_MASTER_CONTROL) ||
                (adr == `CSSM_OFS_GLOBAL_STATUS) ||
                (adr == `CSSM_OFS_IRQ_REQUEST) ||
                (adr == `CSSM_OFS_IRQ_MASK);
  endfunction : isHostReg

  function automatic logic isMailbox(input logic [7:0] adr);
    isMailbox = (adr >= `CSSM_OFS_MAILBOX_BASE) &&
                (adr < `CSSM_OFS_MAILBOX_BASE + 8'(4*`CSSM_MAILBOX_WORDS));
  endfunction : isMailbox

  function automatic logic [7:0] satInc(input logic [7:0] v);
    satInc = (v == `CSSM_ERR_COUNT_MAX) ? v : v + 8'h01;
  endfunction : satInc

  ////////////////////////////////////////////////////////////////////////////
  // Receive pin synchroniser and idle detection.

  always_ff @(posedge clock) begin
    if (srst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= canRxPin;
      rxSync <= rxMeta;
    end
  end

  cssm_recessive_count u_idle (
    .clock    (clock),
    .srst     (srst),
    .run      (state == CSSM_RESYNC),
    .bitTick  (bitTick),
    .rxBit    (rxSync),
    .idleSeen (idleSeen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sleep state machine.

  assign asleep  = (state == CSSM_SLEEP);
  assign busWake = asleep && masterControl[`CSSM_BIT_WAKE_ON_BUS] &&
                   !rxSync;

  always_comb begin
    next_state = state;
    case (state)
      CSSM_NORMAL: begin
        if (masterControl[`CSSM_BIT_SLEEP_REQUEST]) begin
          next_state = CSSM_PEND;
        end
      end
      CSSM_PEND: begin
        if (!masterControl[`CSSM_BIT_SLEEP_REQUEST]) begin
          next_state = CSSM_NORMAL;
        end else if (!busAccessBusy) begin
          next_state = CSSM_SLEEP;
        end
      end
      CSSM_SLEEP: begin
        if (!masterControl[`CSSM_BIT_SLEEP_REQUEST] || busWake) begin
          next_state = CSSM_RESYNC;
        end
      end
      CSSM_RESYNC: begin
        if (idleSeen) begin
          next_state = CSSM_NORMAL;
        end
      end
      default: begin
        next_state = CSSM_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= CSSM_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  // Bus is cut off in sleep and resync; it stays joined in normal and pending.
  assign busJoined = (state == CSSM_NORMAL) || (state == CSSM_PEND);
  assign canTxPin  = busJoined ? coreTx : 1'b1;
  assign coreRx    = busJoined ? rxSync : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Error counters.

  always_ff @(posedge clock) begin
    if (srst) begin
      receiveErrorCount <= `CSSM_RST_ERROR_COUNT;
    end else if (busJoined && recInc) begin
      receiveErrorCount <= satInc(receiveErrorCount);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      transmitErrorCount <= `CSSM_RST_ERROR_COUNT;
    end else if (busJoined && tecInc) begin
      transmitErrorCount <= satInc(transmitErrorCount);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave.

  assign reqLive  = wbCyc && wbStb;
  assign reqOk    = isHostReg(wbAdr) ||
                    (!asleep && (isMailbox(wbAdr) ||
                    wbAdr == `CSSM_OFS_ERROR_COUNT));
  assign writeNow = reqLive && wbWe && wbAck;
  assign mbIdx    = wbAdr[`CSSM_MAILBOX_IDX_W+1:2];

  always_ff @(posedge clock) begin
    if (srst) begin
      wbAck <= 1'b0;
      wbErr <= 1'b0;
    end else begin
      wbAck <= reqLive && !wbAck && !wbErr && reqOk;
      wbErr <= reqLive && !wbAck && !wbErr && !reqOk;
    end
  end

  always_comb begin
    statusWord = 16'h0000;
    statusWord[`CSSM_GS_SLEEP_PEND] = (state == CSSM_PEND);
    statusWord[`CSSM_GS_ASLEEP]     = asleep;
    statusWord[`CSSM_GS_RESYNC]     = (state == CSSM_RESYNC);
  end

  always_comb begin
    readWord = 16'h0000;
    if (wbAdr == `CSSM_OFS_MASTER_CONTROL) begin
      readWord = masterControl;
    end else if (wbAdr == `CSSM_OFS_GLOBAL_STATUS) begin
      readWord = statusWord;
    end else if (wbAdr == `CSSM_OFS_IRQ_REQUEST) begin
      readWord = irqRequest;
    end else if (wbAdr == `CSSM_OFS_IRQ_MASK) begin
      readWord = irqMask;
    end else if (wbAdr == `CSSM_OFS_ERROR_COUNT) begin
      readWord = {transmitErrorCount, receiveErrorCount};
    end else if (isMailbox(wbAdr)) begin
      readWord = mailbox[mbIdx];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wbDatOut <= 32'h00000000;
    end else if (reqLive && !wbWe && !wbAck && !wbErr) begin
      wbDatOut <= {16'h0000, readWord};
    end
  end

  // Mailbox storage; writes are blocked while asleep by the decode.
  always_ff @(posedge clock) begin
    if (writeNow && isMailbox(wbAdr)) begin
      if (wbSel[0]) begin
        mailbox[mbIdx][7:0] <= wbDatIn[7:0];
      end
      if (wbSel[1]) begin
        mailbox[mbIdx][15:8] <= wbDatIn[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master control and interrupt registers.

  always_ff @(posedge clock) begin
    if (srst) begin
      masterControl <= `CSSM_RST_MASTER_CONTROL;
    end else begin
      if (writeNow && wbSel[0] &&
          wbAdr == `CSSM_OFS_MASTER_CONTROL) begin
        masterControl[`CSSM_BIT_SLEEP_REQUEST] <=
          wbDatIn[`CSSM_BIT_SLEEP_REQUEST];
        masterControl[`CSSM_BIT_WAKE_ON_BUS] <=
          wbDatIn[`CSSM_BIT_WAKE_ON_BUS];
      end
      if (busWake) begin
        masterControl[`CSSM_BIT_SLEEP_REQUEST] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irqMask <= `CSSM_RST_IRQ_MASK;
    end else if (writeNow && wbSel[0] && wbAdr == `CSSM_OFS_IRQ_MASK) begin
      irqMask[`CSSM_IRQ_SLEEP]  <= wbDatIn[`CSSM_IRQ_SLEEP];
      irqMask[`CSSM_IRQ_RX_MSG] <= wbDatIn[`CSSM_IRQ_RX_MSG];
      irqMask[`CSSM_IRQ_WAKE]   <= wbDatIn[`CSSM_IRQ_WAKE];
    end
  end

  // Write one clears, except the receive flag while asleep; a set in the same cycle wins.
  always_ff @(posedge clock) begin
    if (srst) begin
      irqRequest <= `CSSM_RST_IRQ_REQUEST;
    end else begin
      if (writeNow && wbSel[0] && wbAdr == `CSSM_OFS_IRQ_REQUEST) begin
        if (wbDatIn[`CSSM_IRQ_SLEEP]) begin
          irqRequest[`CSSM_IRQ_SLEEP] <= 1'b0;
        end
        if (wbDatIn[`CSSM_IRQ_RX_MSG] && !asleep) begin
          irqRequest[`CSSM_IRQ_RX_MSG] <= 1'b0;
        end
        if (wbDatIn[`CSSM_IRQ_WAKE]) begin
          irqRequest[`CSSM_IRQ_WAKE] <= 1'b0;
        end
      end
      if (state == CSSM_PEND && next_state == CSSM_SLEEP) begin
        irqRequest[`CSSM_IRQ_SLEEP] <= 1'b1;
      end
      if (rxPending) begin
        irqRequest[`CSSM_IRQ_RX_MSG] <= 1'b1;
      end
      if (busWake) begin
        irqRequest[`CSSM_IRQ_WAKE] <= 1'b1;
      end
    end
  end

  assign irq = |(irqRequest & ~irqMask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_sleep_waits_access: assert property (@(posedge clock) disable iff (srst)
    (state == CSSM_PEND && busAccessBusy) |=> state != CSSM_SLEEP)
    else $error("Sleep entered during a bus access.");

  a_sleep_tx_recessive: assert property (@(posedge clock) disable iff (srst)
    (asleep || state == CSSM_RESYNC) |-> (canTxPin && coreRx))
    else $error("Bus not isolated while asleep.");

  a_counters_frozen: assert property (@(posedge clock) disable iff (srst)
    (asleep || state == CSSM_RESYNC) |=>
    ($stable(receiveErrorCount) && $stable(transmitErrorCount)))
    else $error("Error counter changed in sleep.");

  a_clear_leaves_sleep: assert property (@(posedge clock) disable iff (srst)
    (asleep && !masterControl[`CSSM_BIT_SLEEP_REQUEST]) |=>
    state == CSSM_RESYNC)
    else $error("Sleep not left after clear.");

  a_resync_needs_idle: assert property (@(posedge clock) disable iff (srst)
    (state == CSSM_RESYNC && !idleSeen) |=> state != CSSM_NORMAL)
    else $error("Rejoined bus before idle seen.");

  a_sleep_irq_set: assert property (@(posedge clock) disable iff (srst)
    ($rose(asleep)) |-> irqRequest[`CSSM_IRQ_SLEEP])
    else $error("Sleep entry flag not raised.");

  a_mailbox_refused: assert property (@(posedge clock) disable iff (srst)
    (reqLive && asleep && isMailbox(wbAdr) && !wbAck && !wbErr) |=>
    (wbErr && !wbAck))
    else $error("Mailbox access not refused in sleep.");

  a_rxirq_held: assert property (@(posedge clock) disable iff (srst)
    (asleep && $past(asleep) && $past(irqRequest[`CSSM_IRQ_RX_MSG])) |->
    irqRequest[`CSSM_IRQ_RX_MSG])
    else $error("Receive flag cleared in sleep.");

  a_reserved_zero: assert property (@(posedge clock) disable iff (srst)
    masterControl[4:3] == 2'h0)
    else $error("Reserved control bits not zero.");

  a_wake_clears_req: assert property (@(posedge clock) disable iff (srst)
    busWake |=> (!masterControl[`CSSM_BIT_SLEEP_REQUEST] &&
    state == CSSM_RESYNC))
    else $error("Bus wake did not clear request.");

endmodule : cssm_sleep_ctrl

// ===== cssm_can_partner.sv
// Model of the CAN bus and protocol core facing the sleep-mode block.
// Assumes the bench commands dominant bits, bit ticks and frame activity.
`timescale 1ns/1ps

module cssm_can_partner (
  input  wire logic clock,
  input  wire logic canTxPin,
  input  wire logic tickEn,
  input  wire logic domReq,
  input  wire logic busyReq,
  output logic      canRxPin,
  output logic      bitTick,
  output logic      busAccessBusy,
  output int        tickCount
);
  logic [1:0] phase = 2'h0;
  logic       tick = 1'b0;
  int         ticks = 0;

  // The bus is wired-AND with a recessive pull-up.
  assign canRxPin = domReq ? 1'b0 : canTxPin;
  assign busAccessBusy = busyReq;
  assign bitTick = tick;
  assign tickCount = ticks;

  // One sample point every four clocks while ticks are enabled.
  always_ff @(posedge clock) begin
    phase <= tickEn ? phase + 2'h1 : 2'h0;
    tick <= tickEn && phase == 2'h3;
    if (tickEn && phase == 2'h3) begin
      ticks <= ticks + 1;
    end
  end
endmodule : cssm_can_partner

// ===== can_sleep_mode_control_bench.sv
// Self-checking bench for the CAN sleep-mode control block.
// Assumes the design files and cssm_can_partner.sv are compiled first.
`timescale 1ns/1ps
`include "cssm_cfg.svh"

module can_sleep_mode_control_bench;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0;
  logic        coreTx = 1'b1;
  logic        recInc = 1'b0;
  logic        tecInc = 1'b0;
  logic        rxPending = 1'b0;
  logic        tickEn = 1'b0;
  logic        domReq = 1'b0;
  logic        busyReq = 1'b0;
  logic [31:0] wbDatOut;
  logic        wbAck, wbErr, canRxPin, bitTick, busAccessBusy;
  logic        canTxPin, coreRx, busJoined, irq;
  int          tickCount;
  logic [31:0] rdat;
  logic        rerr;
  int          fails = 0;
  int          checked = 0;
  int          receive_error_count = 0;
  int          transmit_error_count = 0;
  int          mbox [16];
  int          k, t0;

  always #50 clock = ~clock;

  cssm_sleep_ctrl u_cssm_sleep_ctrl (
    .clock(clock), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .wbErr(wbErr),
    .canRxPin(canRxPin), .coreTx(coreTx), .bitTick(bitTick),
    .busAccessBusy(busAccessBusy), .recInc(recInc), .tecInc(tecInc),
    .rxPending(rxPending), .canTxPin(canTxPin), .coreRx(coreRx),
    .busJoined(busJoined), .irq(irq)
  );

  cssm_can_partner u_cssm_can_partner (
    .clock(clock), .canTxPin(canTxPin), .tickEn(tickEn),
    .domReq(domReq), .busyReq(busyReq), .canRxPin(canRxPin),
    .bitTick(bitTick), .busAccessBusy(busAccessBusy),
    .tickCount(tickCount)
  );

  ////////////////////////////////////////
  task chk(input string name, input logic [31:0] seen,
           input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // One classic Wishbone cycle; the answer is taken while ack stands.
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatIn <= d;
    wbSel <= 4'h3;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    rdat = wbDatOut;
    rerr = wbErr;
    if (wbAck !== 1'b1 && wbErr !== 1'b1) begin
      fails++;
      test_done();
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb

  task bump(input int n, input bit live);
    repeat (n) begin
      @(posedge clock);
      recInc <= 1'b1;
      tecInc <= 1'b1;
      @(posedge clock);
      recInc <= 1'b0;
      tecInc <= 1'b0;
    end
    if (live) begin
      receive_error_count += n;
      transmit_error_count += n;
    end
  endtask : bump

  // Enables bit ticks and counts them until the bus is rejoined.
  task rejoin;
    int n;
    t0 = tickCount;
    tickEn <= 1'b1;
    for (n = 0; n < 400 && busJoined !== 1'b1; n++) @(negedge clock);
    if (n == 400) begin
      fails++;
      test_done();
    end
    chk("recessive ticks", 32'(tickCount - t0), 32'h0000000B);
    @(posedge clock);
    tickEn <= 1'b0;
  endtask : rejoin

  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hA3BCA03D));
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    for (k = 0; k < 5; k++) begin
      wb(1'b0, 8'(k * 4), 32'h0);
      chk("reset value", rdat, 32'h0);
    end
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'(rerr), 32'h1);
    for (k = 0; k < 4; k++) begin
      t0 = $urandom_range(15);
      mbox[t0] = $urandom_range(16'hFFFF);
      wb(1'b1, `CSSM_OFS_MAILBOX_BASE + 8'(t0 * 4), 32'(mbox[t0]));
      wb(1'b0, `CSSM_OFS_MAILBOX_BASE + 8'(t0 * 4), 32'h0);
      chk("mailbox", rdat, 32'(mbox[t0]));
    end
    bump(1 + $urandom_range(4), 1'b1);
    wb(1'b0, `CSSM_OFS_ERROR_COUNT, 32'h0);
    chk("err count", rdat, 32'((transmit_error_count << 8) | receive_error_count));
    wb(1'b1, `CSSM_OFS_IRQ_REQUEST, 32'h7);
    busyReq <= 1'b1;
    wb(1'b1, `CSSM_OFS_MASTER_CONTROL, 32'hA0);
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("pending", rdat, 32'h1);
    chk("joined pend", 32'(busJoined), 32'h1);
    busyReq <= 1'b0;
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("asleep", rdat, 32'h2);
    wb(1'b0, `CSSM_OFS_IRQ_REQUEST, 32'h0);
    chk("sleep flag", rdat, 32'h1);
    chk("irq line", 32'(irq), 32'h1);
    wb(1'b0, `CSSM_OFS_MASTER_CONTROL, 32'h0);
    chk("control", rdat, 32'hA0);
    coreTx <= 1'b0;
    @(negedge clock);
    chk("tx idle", 32'(canTxPin), 32'h1);
    chk("joined sleep", 32'(busJoined), 32'h0);
    @(posedge clock);
    coreTx <= 1'b1;
    bump(3, 1'b0);
    wb(1'b0, `CSSM_OFS_ERROR_COUNT, 32'h0);
    chk("frozen sleep", rdat, 32'((transmit_error_count << 8) | receive_error_count));
    wb(1'b0, `CSSM_OFS_MAILBOX_BASE, 32'h0);
    chk("mailbox refused", 32'(rerr), 32'h1);
    @(posedge clock);
    rxPending <= 1'b1;
    @(posedge clock);
    rxPending <= 1'b0;
    wb(1'b1, `CSSM_OFS_IRQ_REQUEST, 32'h3);
    wb(1'b0, `CSSM_OFS_IRQ_REQUEST, 32'h0);
    chk("rx flag held", rdat, 32'h2);
    wb(1'b1, `CSSM_OFS_IRQ_MASK, 32'h7);
    @(negedge clock);
    chk("irq masked", 32'(irq), 32'h0);
    wb(1'b1, `CSSM_OFS_IRQ_MASK, 32'h0);
    @(posedge clock);
    domReq <= 1'b1;
    repeat (4) @(posedge clock);
    domReq <= 1'b0;
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("bus wake", rdat, 32'h4);
    wb(1'b0, `CSSM_OFS_MASTER_CONTROL, 32'h0);
    chk("auto clear", rdat, 32'h80);
    wb(1'b0, `CSSM_OFS_IRQ_REQUEST, 32'h0);
    chk("wake flag", rdat, 32'h6);
    bump(2, 1'b0);
    wb(1'b0, `CSSM_OFS_ERROR_COUNT, 32'h0);
    chk("frozen resync", rdat, 32'((transmit_error_count << 8) | receive_error_count));
    rejoin();
    wb(1'b1, `CSSM_OFS_IRQ_REQUEST, 32'h7);
    wb(1'b1, `CSSM_OFS_MASTER_CONTROL, 32'h20);
    @(posedge clock);
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("asleep again", rdat, 32'h2);
    @(posedge clock);
    domReq <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk("rx ignored", 32'(coreRx), 32'h1);
    @(posedge clock);
    domReq <= 1'b0;
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("no wake", rdat, 32'h2);
    wb(1'b1, `CSSM_OFS_MASTER_CONTROL, 32'h0);
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("soft wake", rdat, 32'h4);
    rejoin();
    coreTx <= 1'b0;
    @(negedge clock);
    chk("tx joined", 32'(canTxPin), 32'h0);
    @(posedge clock);
    coreTx <= 1'b1;
    bump(1, 1'b1);
    wb(1'b0, `CSSM_OFS_ERROR_COUNT, 32'h0);
    chk("counting", rdat, 32'((transmit_error_count << 8) | receive_error_count));
    busyReq <= 1'b1;
    wb(1'b1, `CSSM_OFS_MASTER_CONTROL, 32'h20);
    wb(1'b1, `CSSM_OFS_MASTER_CONTROL, 32'h0);
    busyReq <= 1'b0;
    wb(1'b0, `CSSM_OFS_GLOBAL_STATUS, 32'h0);
    chk("cancelled", rdat, 32'h0);
    test_done();
  end
endmodule : can_sleep_mode_control_bench
